// file: bench/lsc_link_core_tb.sv
`timescale 1ns/1ps
module lsc_link_core_tb;
	import lsc_pkg::*;
	logic core_clk = 1'b0;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] cfg = 2'h0;
	logic fast_rate_select = 1'b0;
	logic tx_valid = 1'b0;
	logic out_port_taken = 1'b0;
	logic irq_enable = 1'b0;
	logic host_rd = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] ack_wait = 8'h00;
	logic [3:0] bc = SLOW_BIT_CYC;
	logic rx_line, tx_line, tx_ready, opv, ipa, rxi, txi, oe_n;
	logic [7:0] pob, hdb;
	logic [7:0] exp_out[$];
	logic [7:0] exp_in[$];
	int num_errors = 0;
	int cmp_count = 0;
	int seed_dummy;
	int saw_full;
	wire logic strap = cfg[1] ? (cfg[0] ? ref_clk : 1'b1) : 1'b0;

	// core clock 100 MHz, reference 5 MHz running from time zero
	// the long power-on warm-up of the reference is cut short to keep the run brief
	always #5 core_clk = ~core_clk;
	always #100 ref_clk = ~ref_clk;

	lsc_link_core u_lsc_link_core (.core_clk(core_clk), .rst_n(rst_n), .mode_speed_strap(strap),
		.fast_rate_select(fast_rate_select), .serial_rx_line(rx_line), .serial_tx_line(tx_line),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .parallel_out_bus(pob),
		.out_port_valid(opv), .out_port_taken(out_port_taken), .in_port_acknowledge(ipa),
		.rx_full_irq(rxi), .tx_empty_irq(txi), .irq_enable(irq_enable), .host_rd(host_rd),
		.host_data_bus(hdb), .host_data_oe_n(oe_n));

	lsc_peer_model u_lsc_peer_model (.core_clk(core_clk), .from_dut(tx_line), .to_dut(rx_line),
		.bit_cyc(bc), .ack_wait(ack_wait));

	// compare and count
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// print counts and verdict, end the run
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// reset with straps set for the new configuration
	task automatic do_reset(input logic [1:0] c);
		rst_n <= 1'b0;
		cfg <= c;
		fast_rate_select <= c[0];
		irq_enable <= ~c[1];
		bc <= c[0] ? FAST_BIT_CYC : SLOW_BIT_CYC;
		// reset spans eight reference periods, released on a core edge
		repeat (8) @(posedge ref_clk);
		@(posedge core_clk);
		check("outputs in reset", 8'h01, {2'b0, tx_line, opv, ipa, rxi, txi, oe_n});
		rst_n <= 1'b1;
		// straps settle and a clocked strap is recognised before traffic starts
		repeat (24) @(posedge core_clk);
	endtask

	// hand bytes to the transmit fifo, holding each until taken
	task automatic push_bytes(input int n);
		logic [7:0] d;
		int t;
		for (int i = 0; i < n; i++) begin
			d = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($urandom);
			tx_data <= d;
			tx_valid <= 1'b1;
			t = 0;
			do begin
				@(posedge core_clk);
				t++;
				if (tx_ready !== 1'b1) saw_full = 1;
			end while (tx_ready !== 1'b1 && t < 20000);
			exp_out.push_back(d);
		end
		tx_valid <= 1'b0;
	endtask

	// feed the peer and consume what arrives, delaying each take
	task automatic take_bytes(input int n);
		logic [7:0] d;
		int t;
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			u_lsc_peer_model.tx_q.push_back(d);
			exp_in.push_back(d);
		end
		for (int i = 0; i < n; i++) begin
			t = 0;
			while ((cfg[1] ? opv : rxi) !== 1'b1 && t < 5000) begin
				@(posedge core_clk);
				t++;
			end
			host_rd <= ~cfg[1];
			repeat ($urandom_range(40, 3)) @(posedge core_clk);
			d = exp_in.pop_front();
			check("received byte", d, pob);
			if (!cfg[1]) check("host bus", d, hdb);
			check("host drive", {7'b0, cfg[1]}, {7'b0, oe_n});
			// only acks for bytes already taken may have reached the peer
			check("acks before take", 8'(i), 8'(u_lsc_peer_model.acks_in));
			out_port_taken <= 1'b1;
			host_rd <= 1'b0;
			@(posedge core_clk);
			out_port_taken <= 1'b0;
			// let the take clear the valid flag before looking for the next byte
			@(posedge core_clk);
		end
	endtask

	// watchdog sized well above the longest configuration
	initial begin
		#900000;
		num_errors++;
		give_verdict();
	end

	// one pass per strap configuration, traffic both ways at once
	initial begin
		int n;
		int t;
		seed_dummy = $urandom(32'h5b3a);
		for (int c = 0; c < 4; c++) begin
			do_reset(2'(c));
			saw_full = 0;
			n = (c == 0) ? 40 : 8;
			ack_wait <= (c == 0) ? 8'd200 : 8'($urandom_range(20, 0));
			fork
				push_bytes(n);
				take_bytes(n);
			join
			// wait for the peer to hold every byte and every acknowledge
			t = 0;
			while ((u_lsc_peer_model.rx_q.size() < n || u_lsc_peer_model.owed > 0 ||
				u_lsc_peer_model.acks_in < n) && t < 20000) begin
				@(posedge core_clk);
				t++;
			end
			repeat (60) @(posedge core_clk);
			check("bytes at peer", 8'(n), 8'(u_lsc_peer_model.rx_q.size()));
			while (u_lsc_peer_model.rx_q.size() > 0 && exp_out.size() > 0)
				check("sent byte", exp_out.pop_front(), u_lsc_peer_model.rx_q.pop_front());
			check("framing faults", 8'h00, 8'(u_lsc_peer_model.faults));
			check("acks from device", 8'(n), 8'(u_lsc_peer_model.acks_in));
			check("idle line", 8'h00, {7'b0, tx_line});
			check("done flags", cfg[1] ? 8'h02 : 8'h01, {6'b0, ipa, txi});
			if (c == 0) check("fifo refused", 8'h01, 8'(saw_full));
			u_lsc_peer_model.acks_in = 0;
			exp_out.delete();
		end
		give_verdict();
	end
endmodule

// file: bench/lsc_peer_model.sv
`timescale 1ns/1ps
module lsc_peer_model (
	// clock
	input wire logic core_clk,
	// link lines
	input wire logic from_dut,
	output logic to_dut,
	// bit time and ack delay in core cycles
	input wire logic [3:0] bit_cyc,
	input wire logic [7:0] ack_wait
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic [7:0] b;
	int acks_in = 0;
	int owed = 0;
	int credit = 1;
	int faults = 0;

	// line rests low, also through reset
	initial to_dut = 1'b0;

	// send one packet bit 0 first, then fall back to idle low
	task automatic send(input logic [10:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			to_dut <= #3 v[i];
			repeat (bit_cyc) @(posedge core_clk);
		end
		to_dut <= #3 1'b0;
	endtask

	// owed acks go first, data only with credit
	always begin
		@(posedge core_clk);
		if (owed > 0) begin
			repeat (ack_wait) @(posedge core_clk);
			owed--;
			send(11'h001, 2);
		end else if (credit > 0 && tx_q.size() > 0) begin
			credit--;
			send({1'b0, tx_q.pop_front(), 2'b11}, 11);
		end
	end

	// decode incoming packets at bit centres
	always begin
		@(negedge core_clk iff from_dut === 1'b1);
		repeat (bit_cyc + bit_cyc / 2) @(negedge core_clk);
		if (from_dut === 1'b0) begin
			acks_in++;
			credit++;
		end else begin
			if (owed > 0) faults++;
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cyc) @(negedge core_clk);
				b[i] = from_dut;
			end
			repeat (bit_cyc) @(negedge core_clk);
			if (from_dut !== 1'b0) faults++;
			rx_q.push_back(b);
			owed++;
		end
	end
endmodule

// file: logic/lsc_fifo.sv
`timescale 1ns/1ps
module lsc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	// handshakes on both sides
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];

	// occupancy after this cycle
	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	// pointers, count and a registered ready
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= next_count;
			in_ready <= next_count != FULL_CNT;
		end
	end

	// storage, indexed by the write pointer
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	a_fifo_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		push && !pop |=> count == $past(count) + 1'b1)
		else $error("fifo count did not grow on a push");
	a_fifo_no_overrun: assert property (@(posedge core_clk) disable iff (!rst_n)
		count == FULL_CNT |-> !in_ready)
		else $error("fifo accepts data while full");
endmodule

// file: logic/lsc_link_core.sv
`timescale 1ns/1ps
// Function
// - serial output rests low whenever no packet is in flight
// - data packet: high start, one, eight data bits, low stop
// - data bits go least significant first, most significant just before stop
// - acknowledge packet is a high start bit then a zero bit
// - next data byte waits until the previous byte is acknowledged
// - every received byte earns exactly one acknowledge on our output
// - acknowledge goes out only after the consumer took the byte
// - receive and transmit paths run independently and at the same time
// - incoming line is sampled asynchronously, any peer clock phase tolerated
// - bit times count core clock cycles, 10 per bit slow and 5 per bit fast
// - strap high gives peripheral mode slow; strap clocked gives peripheral fast
// - strap low gives bus mode with speed from the rate select pin
// - bus mode: rate select low is 10, high is 20 Mbit/s
// - reset holds serial output and handshake outputs low
// - reset disables interrupts and floats the host data bus
module lsc_link_core
	import lsc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// mode and speed straps
	input wire logic mode_speed_strap,
	input wire logic fast_rate_select,
	// serial link
	input wire logic serial_rx_line,
	output logic serial_tx_line,
	// outbound bytes
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// inbound bytes
	output logic [7:0] parallel_out_bus,
	output logic out_port_valid,
	input wire logic out_port_taken,
	// handshake and interrupt outputs, interrupt enable input
	output logic in_port_acknowledge,
	output logic rx_full_irq,
	output logic tx_empty_irq,
	input wire logic irq_enable,
	// host data bus
	input wire logic host_rd,
	output logic [7:0] host_data_bus,
	output logic host_data_oe_n
);
	lsc_rx_if lnk ();

	logic strap_s1;
	logic strap_s2;
	logic strap_prev;
	logic [5:0] strap_win;
	logic [1:0] strap_warm;
	logic strap_clocked;
	logic periph_mode;
	logic fast_link;

	logic fifo_valid;
	logic [7:0] fifo_data;

	lsc_tx_state_e tx_st;
	logic [9:0] tx_sreg;
	logic [3:0] tx_nleft;
	logic [3:0] tx_cnt;
	logic tx_is_data;
	logic await_ack;
	logic ack_owed;
	logic ack_load;
	logic data_load;

	logic rx_full;
	logic next_rx_full;
	logic take;

	// outbound byte buffer, drained by the transmitter one packet at a time
	lsc_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(fifo_valid),
		.out_ready(data_load),
		.out_data(fifo_data)
	);

	// receive path runs on its own, side by side with the transmitter
	lsc_rx u_rx (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.rx_line(serial_rx_line),
		.lnk(lnk.rx)
	);

	// strap synchroniser
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_s1 <= 1'b0;
			strap_s2 <= 1'b0;
		end else begin
			strap_s1 <= mode_speed_strap;
			strap_s2 <= strap_s1;
		end
	end

	// strap watcher: edges within the window mean it carries the reference clock
	// compares wait until the synchroniser has flushed its reset zeros, else a
	// strap tied high would look like one clock edge and pick the fast rate
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_warm <= 2'h0;
			strap_prev <= 1'b0;
			strap_win <= 6'h00;
		end else begin
			strap_prev <= strap_s2;
			if (strap_warm != STRAP_WARM_CYC) begin
				strap_warm <= strap_warm + 2'h1;
			end else if (strap_s2 != strap_prev) begin
				strap_win <= STRAP_WIN_CYC;
			end else if (strap_win != 6'h00) begin
				strap_win <= strap_win - 6'h01;
			end
		end
	end

	// mode and rate decode
	assign strap_clocked = strap_win != 6'h00;
	assign periph_mode = strap_clocked || strap_prev;
	assign fast_link = periph_mode ? strap_clocked : fast_rate_select;

	// bit time in core cycles
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lnk.bit_cyc <= SLOW_BIT_CYC;
		end else begin
			lnk.bit_cyc <= fast_link ? FAST_BIT_CYC : SLOW_BIT_CYC;
		end
	end

	// packet selection at a boundary: owed acknowledge beats data
	assign ack_load = tx_st == TX_IDLE && ack_owed;
	assign data_load = tx_st == TX_IDLE && !ack_owed && fifo_valid && !await_ack;

	// transmitter: first bit leaves at load, the rest shift out of tx_sreg
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st <= TX_IDLE;
			tx_sreg <= 10'h000;
			tx_nleft <= 4'h0;
			tx_cnt <= 4'h0;
			tx_is_data <= 1'b0;
			serial_tx_line <= 1'b0;
		end else begin
			case (tx_st)
				TX_IDLE: begin
					serial_tx_line <= 1'b0;
					tx_cnt <= lnk.bit_cyc - 4'h1;
					if (ack_load) begin
						serial_tx_line <= 1'b1;
						tx_sreg <= 10'h000;
						tx_nleft <= ACK_PKT_BITS - 4'h1;
						tx_is_data <= 1'b0;
						tx_st <= TX_SEND;
					end else if (data_load) begin
						serial_tx_line <= 1'b1;
						tx_sreg <= {1'b0, fifo_data, 1'b1};
						tx_nleft <= DATA_PKT_BITS - 4'h1;
						tx_is_data <= 1'b1;
						tx_st <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (tx_cnt != 4'h0) begin
						tx_cnt <= tx_cnt - 4'h1;
					end else if (tx_nleft == 4'h0) begin
						serial_tx_line <= 1'b0;
						tx_st <= TX_IDLE;
					end else begin
						serial_tx_line <= tx_sreg[0];
						tx_sreg <= {1'b0, tx_sreg[9:1]};
						tx_nleft <= tx_nleft - 4'h1;
						tx_cnt <= lnk.bit_cyc - 4'h1;
					end
				end
				default: tx_st <= TX_IDLE;
			endcase
		end
	end

	// outstanding data byte, freed by the peer's acknowledge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			await_ack <= 1'b0;
		end else if (data_load) begin
			await_ack <= 1'b1;
		end else if (lnk.ack_stb) begin
			await_ack <= 1'b0;
		end
	end

	// acknowledge credit: owed once the consumer took the byte
	assign take = rx_full && out_port_taken;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_owed <= 1'b0;
		end else if (take) begin
			ack_owed <= 1'b1;
		end else if (ack_load) begin
			ack_owed <= 1'b0;
		end
	end

	// receive holding byte, a new byte wins over a take in the same cycle
	assign next_rx_full = lnk.data_stb || (rx_full && !take);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_full <= 1'b0;
			parallel_out_bus <= 8'h00;
			out_port_valid <= 1'b0;
			rx_full_irq <= 1'b0;
		end else begin
			rx_full <= next_rx_full;
			if (lnk.data_stb) begin
				parallel_out_bus <= lnk.data;
			end
			out_port_valid <= periph_mode && next_rx_full;
			rx_full_irq <= !periph_mode && irq_enable && next_rx_full;
		end
	end

	// handshake and empty indication
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_port_acknowledge <= 1'b0;
			tx_empty_irq <= 1'b0;
		end else begin
			if (data_load || !periph_mode) begin
				in_port_acknowledge <= 1'b0;
			end else if (lnk.ack_stb) begin
				in_port_acknowledge <= 1'b1;
			end
			tx_empty_irq <= !periph_mode && irq_enable && !fifo_valid && !await_ack;
		end
	end

	// host bus: driven only on a bus-mode read, floated through reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_data_bus <= 8'h00;
			host_data_oe_n <= 1'b1;
		end else begin
			host_data_bus <= parallel_out_bus;
			host_data_oe_n <= !(!periph_mode && host_rd);
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_data_load;
		data_load;
	endsequence
	sequence s_ack_load;
		ack_load;
	endsequence
	sequence s_last_data_bit;
		tx_st == TX_SEND && tx_is_data && tx_nleft == 4'h0;
	endsequence

	a_idle_low: assert property (tx_st == TX_IDLE |-> !serial_tx_line)
		else $error("link output not low while idle");
	a_data_head: assert property (
		s_data_load |=> serial_tx_line && tx_sreg[0] && tx_nleft == DATA_PKT_BITS - 4'h1)
		else $error("data packet does not open with start and one bits");
	a_stop_low: assert property (s_last_data_bit |-> !serial_tx_line)
		else $error("data packet stop bit not low");
	a_lsb_first: assert property (
		s_data_load |=> tx_sreg[8:1] == $past(fifo_data) && !tx_sreg[9])
		else $error("data bits not queued least significant first");
	a_ack_shape: assert property (
		s_ack_load |=> serial_tx_line && tx_nleft == ACK_PKT_BITS - 4'h1 && !tx_sreg[0])
		else $error("acknowledge packet malformed");
	a_hold_for_ack: assert property (
		s_data_load ##1 !lnk.ack_stb |=> await_ack && !data_load)
		else $error("second byte sent before acknowledge");
	a_ack_once: assert property (s_ack_load |=> !ack_owed && tx_st == TX_SEND)
		else $error("acknowledge credit not consumed");
	a_credit_after_take: assert property (take |=> ack_owed && !rx_full)
		else $error("take did not raise acknowledge credit");
	a_ack_priority: assert property (
		tx_st == TX_IDLE && ack_owed && fifo_valid |-> ack_load && !data_load)
		else $error("data sent ahead of owed acknowledge");
	a_rate_pick: assert property (
		(!periph_mode && fast_rate_select) [*2] |-> lnk.bit_cyc == FAST_BIT_CYC)
		else $error("bus mode fast rate not applied");
	a_duplex: assert property (
		lnk.data_stb && tx_st == TX_SEND && tx_cnt != 4'h0 |=> tx_st == TX_SEND)
		else $error("receive disturbed the transmitter");
endmodule

// file: logic/lsc_rx.sv
`timescale 1ns/1ps
module lsc_rx
	import lsc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// raw incoming line
	input wire logic rx_line,
	// decoded packets
	lsc_rx_if.rx lnk
);
	logic sync1;
	logic line;
	lsc_rx_state_e state;
	logic [3:0] cnt;
	logic [3:0] nbit;
	logic [7:0] shreg;

	// two-flop synchroniser, the peer clock has any phase to ours
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 1'b0;
			line <= 1'b0;
		end else begin
			sync1 <= rx_line;
			line <= sync1;
		end
	end

	// oversampled decoder: find start edge, then sample at bit centres
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= RX_IDLE;
			cnt <= 4'h0;
			nbit <= 4'h0;
			shreg <= 8'h00;
			lnk.data <= 8'h00;
			lnk.data_stb <= 1'b0;
			lnk.ack_stb <= 1'b0;
		end else begin
			lnk.data_stb <= 1'b0;
			lnk.ack_stb <= 1'b0;
			case (state)
				RX_IDLE: begin
					if (line) begin
						cnt <= lnk.bit_cyc + (lnk.bit_cyc >> 1) - 4'h1;
						state <= RX_FLAG;
					end
				end
				RX_FLAG: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else if (!line) begin
						lnk.ack_stb <= 1'b1;
						state <= RX_IDLE;
					end else begin
						cnt <= lnk.bit_cyc - 4'h1;
						nbit <= 4'h0;
						state <= RX_DATA;
					end
				end
				RX_DATA: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else begin
						shreg <= {line, shreg[7:1]};
						cnt <= lnk.bit_cyc - 4'h1;
						nbit <= nbit + 4'h1;
						if (nbit == DATA_BITS - 4'h1) begin
							state <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else begin
						if (!line) begin
							lnk.data <= shreg;
							lnk.data_stb <= 1'b1;
						end
						state <= RX_IDLE;
					end
				end
				default: state <= RX_IDLE;
			endcase
		end
	end

	sequence s_flag_zero;
		state == RX_FLAG && cnt == 4'h0 && !line;
	endsequence

	a_ack_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_flag_zero |=> lnk.ack_stb && state == RX_IDLE)
		else $error("acknowledge packet not decoded");
	a_start_detect: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == RX_IDLE && line |=> state == RX_FLAG && cnt > lnk.bit_cyc - 4'h1)
		else $error("start bit not caught or centre offset wrong");
endmodule

// file: pkg/lsc_pkg.sv
package lsc_pkg;
	// core clock and link bit timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int REF_PERIOD_NS = 200;
	localparam int SLOW_BIT_NS = 100;
	localparam int FAST_BIT_NS = 50;
	localparam logic [3:0] SLOW_BIT_CYC = 4'(SLOW_BIT_NS / CLK_PERIOD_NS);
	localparam logic [3:0] FAST_BIT_CYC = 4'(FAST_BIT_NS / CLK_PERIOD_NS);
	// strap counts as clocked while an edge was seen within two reference periods
	localparam logic [5:0] STRAP_WIN_CYC = 6'(2 * REF_PERIOD_NS / CLK_PERIOD_NS);
	// edges until the strap synchroniser holds real samples after reset
	localparam logic [1:0] STRAP_WARM_CYC = 2'h3;
	// packet shapes
	localparam logic [3:0] DATA_PKT_BITS = 4'hb;
	localparam logic [3:0] ACK_PKT_BITS = 4'h2;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 32;

	// receiver states
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_FLAG = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} lsc_rx_state_e;

	// transmitter states
	typedef enum logic [1:0] {
		TX_IDLE = 2'h1,
		TX_SEND = 2'h2
	} lsc_tx_state_e;
endpackage

// file: pkg/lsc_rx_if.sv
`timescale 1ns/1ps
interface lsc_rx_if;
	logic [3:0] bit_cyc;
	logic [7:0] data;
	logic data_stb;
	logic ack_stb;
	// receiver decodes, core sets the bit time
	modport rx (input bit_cyc, output data, output data_stb, output ack_stb);
	modport core (output bit_cyc, input data, input data_stb, input ack_stb);
endinterface
